// *** src/asma_pkg.sv ***
package asma_pkg;
  // access kinds, one request line each
  localparam int KINDS = 10;
  localparam int K_DWR = 0;
  localparam int K_PWR = 1;
  localparam int K_GWR = 2;
  localparam int K_DRD = 3;
  localparam int K_PRD = 4;
  localparam int K_GRD = 5;
  localparam int K_FET = 6;
  localparam int K_AFET = 7;
  localparam int K_AWR = 8;
  localparam int K_ARD = 9;
  localparam logic [KINDS-1:0] WR_KINDS = 10'h107;
  ////////////////////////////////////////////////////////////////////////
  localparam int TASKS = 8;
  localparam int AW = 6;
  localparam int DW = 16;
  localparam int TW = 3;
  localparam int BLOCKS = 4;
  localparam logic [TW-1:0] T_PERI = 3'h4;
  localparam logic [DW-1:0] PROG_BASE = 16'h0000;
  ////////////////////////////////////////////////////////////////////////
  localparam int CFG_W = 7;
  localparam int CFG_PROG = 0;
  localparam int CFG_RAM_LSB = 1;
  localparam int CFG_SHARE_LSB = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam int CFG_DELAY_CYCLES = 2;
  localparam logic [1:0] CFG_SETTLE = 2'(CFG_DELAY_CYCLES);
  localparam int PERI_CYCLES = 2;
  localparam logic [1:0] PERI_LAST = 2'(PERI_CYCLES - 1);
  localparam logic [3:0] RANK_NONE = 4'hf;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_RDAT = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_TASK = 8'h18;
  typedef enum {PERI_IDLE, PERI_CPU, PERI_ACC} asma_peri_type;
endpackage

// *** src/asma_if.sv ***
`timescale 1ns/1ps
interface asma_if;
  import asma_pkg::*;
  logic [KINDS-1:0] req;
  logic [KINDS-1:0][TW-1:0] tgt;
  logic [KINDS-1:0][AW-1:0] addr;
  logic [KINDS-1:0][DW-1:0] wdata;
  logic [KINDS-1:0] ack;
  logic [KINDS-1:0][DW-1:0] rdata;
  logic cfg_wr;
  logic [CFG_W-1:0] cfg_data;
  logic accel_running;
  logic cpu_trap;
  logic accel_illegal;
  logic [TASKS-1:0] trig_src;
  logic [TASKS-1:0] task_trigger;
  logic [DW-1:0] task_vector;
  logic [DW-1:0] task_pc;
  logic [TASKS-1:0] task_done;
  logic accel_ovf;
  logic accel_unf;
  logic [TASKS+1:0] host_irq;
  modport dev (input req, tgt, addr, wdata, cfg_wr, cfg_data,
    accel_running, trig_src, task_vector, task_done, accel_ovf, accel_unf,
    output ack, rdata, cpu_trap, accel_illegal, task_trigger, task_pc,
    host_irq);
  modport host (output req, tgt, addr, wdata, cfg_wr, cfg_data,
    accel_running, trig_src, task_vector, task_done, accel_ovf, accel_unf,
    input ack, rdata, cpu_trap, accel_illegal, task_trigger, task_pc,
    host_irq);
endinterface

// *** src/asma_ram_port.sv ***
`timescale 1ns/1ps
module asma_ram_port #(
  parameter bit IS_PROG = 1'b0
) (
  input logic [asma_pkg::KINDS-1:0] req,
  input logic to_accel,
  input logic share,
  input logic running,
  output logic [asma_pkg::KINDS-1:0] serve,
  output logic [asma_pkg::KINDS-1:0] nulled,
  output logic illegal,
  output logic zero_fetch
);
  import asma_pkg::*;
  // lower rank wins; RANK_NONE answers at once with zero or drops the write
  function automatic logic [3:0] rank(input int k, input logic acc,
                                      input logic shr, input logic run);
    logic [3:0] r;
    r = RANK_NONE;
    if (IS_PROG && !acc) begin
      if (k == K_DWR || k == K_PWR || k == K_GWR) r = 4'h0;
      else if (k == K_DRD || k == K_PRD || k == K_GRD) r = 4'h1;
      else if (k == K_FET) r = 4'h2;
    end else if (IS_PROG) begin
      if (k == K_AFET) r = 4'h0;
      // debug blocked while running, avoids lockout by a looping task
      else if (k == K_GWR && !run) r = 4'h1;
      else if (k == K_GRD && !run) r = 4'h2;
    end else if (!acc) begin
      if (k == K_DWR || k == K_PWR || k == K_GWR) r = 4'h0;
      else if (k == K_DRD || k == K_GRD) r = 4'h1;
      else if (k == K_FET || k == K_PRD) r = 4'h2;
    end else begin
      if (k == K_AWR) r = 4'h0;
      else if (k == K_GWR) r = 4'h1;
      else if (k == K_GRD) r = 4'h2;
      else if (k == K_ARD) r = 4'h3;
      // shared block lets cpu data through
      else if (k == K_DWR && shr) r = 4'h1;
      else if (k == K_DRD && shr) r = 4'h2;
    end
    return r;
  endfunction

  logic [3:0] best;
  logic [3:0] r;
  int win;
  always_comb begin
    best = RANK_NONE;
    r = RANK_NONE;
    win = 0;
    nulled = '0;
    serve = '0;
    for (int k = 0; k < KINDS; k++) begin
      r = rank(k, to_accel, share, running);
      // refused kinds answer zero, writes dropped
      if (req[k] && r == RANK_NONE) nulled[k] = 1'b1;
      else if (req[k] && r < best) begin
        best = r;
        win = k;
      end
    end
    if (best != RANK_NONE) serve[win] = 1'b1;
  end
  // accel fetch from cpu-owned program ram
  assign illegal = IS_PROG && !to_accel && req[K_AFET];
  assign zero_fetch = nulled[K_FET];
endmodule

// *** src/asma_device.sv ***
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - cpu-owned program ram: accel fetch is illegal
// - cpu program ram: writes, reads, then fetches
// - accel program ram: accel fetch only, cpu debug
// - accel program ram: cpu reads zero, writes dropped
// - accel fetch, then debug write, debug read
// - running accel: program ram debug reads zero, writes ignored
// - three data blocks with own owner bits
// - cpu data block: accel reads zero, writes dropped
// - cpu data block: writes, data and debug reads, then fetches and program reads
// - unshared accel data block: cpu only debug access
// - shared accel block: cpu data access allowed
// - accel write, cpu write, cpu read, accel read
// - peripheral tie goes to accel, cpu stalls
// - pending accel beats pending cpu access
// - peripheral access in progress never preempted
// - per master, write beats read
// - software avoids shared peripheral locations
// - map write effective within two cycles
// - task starts on falling trigger edge only
// - task vector offsets program ram base
// - task done, overflow, underflow raise interrupts
// - ownership change only with tasks idle
// - task enables zero during setup
module asma_device (
  input wire logic pclk,
  input wire logic presetn,
  asma_if.dev bus,
  output logic [asma_pkg::CFG_W-1:0] map_active
);
  import asma_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg_pend;
    logic cfg_wait;
    logic [CFG_W-1:0] cfg;
    logic [KINDS-1:0] ack;
    logic [KINDS-1:0][DW-1:0] rdata;
    logic trap;
    logic illegal;
    asma_peri_type peri;
    logic [1:0] peri_cnt;
    logic [3:0] peri_kind;
    logic [TASKS-1:0] trig_prev;
    logic [TASKS-1:0] trig;
    logic [DW-1:0] task_pc;
    logic [TASKS+1:0] irq;
  } asma_dev_state_type;

  asma_dev_state_type st_reg;
  asma_dev_state_type st_next;
  // block 0 is program ram, blocks 1 to 3 the data rams
  logic [DW-1:0] mem [BLOCKS][2**AW];
  // peripheral registers, reached by plain data accesses only
  logic [DW-1:0] preg [2**AW];
  logic [KINDS-1:0] rq;
  logic [KINDS-1:0] pq;
  logic [BLOCKS-1:0][KINDS-1:0] breq;
  logic [BLOCKS-1:0][KINDS-1:0] serve;
  logic [BLOCKS-1:0][KINDS-1:0] nulled;
  logic [BLOCKS-1:0] ill;
  logic [BLOCKS-1:0] zfet;
  logic peri_we;

  ////////////////////////////////////////////////////////////////////////
  // a request answered last cycle is masked while its master drops it
  assign rq = bus.req & ~st_reg.ack;

  for (genvar b = 0; b < BLOCKS; b++) begin : g_blk
    for (genvar k = 0; k < KINDS; k++) begin : g_kind
      assign breq[b][k] = rq[k] && bus.tgt[k] == TW'(b);
    end
    asma_ram_port #(
      .IS_PROG(b == 0)
    ) u_port (
      .req(breq[b]),
      .to_accel(b == 0 ? st_reg.cfg[CFG_PROG] : st_reg.cfg[CFG_RAM_LSB+b-1]),
      .share(b == 0 ? 1'b0 : st_reg.cfg[CFG_SHARE_LSB+b-1]),
      .running(bus.accel_running),
      .serve(serve[b]),
      .nulled(nulled[b]),
      .illegal(ill[b]),
      .zero_fetch(zfet[b])
    );
  end

  // peripheral requests go to the shared-bus state machine below
  for (genvar k = 0; k < KINDS; k++) begin : g_peri
    assign pq[k] = rq[k] && bus.tgt[k] == T_PERI;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.ack = '0;
    peri_we = 1'b0;

    // staged twice so ownership settles on the second edge
    st_next.cfg_wait = bus.cfg_wr;
    if (bus.cfg_wr) st_next.cfg_pend = bus.cfg_data;
    if (st_reg.cfg_wait) st_next.cfg = st_reg.cfg_pend;

    // losers keep requesting and are ranked again next cycle;
    // a steady stream of higher ranks can starve them
    for (int k = 0; k < KINDS; k++) begin
      // unmapped targets answer zero at once
      if (rq[k] && bus.tgt[k] > T_PERI) begin
        st_next.ack[k] = 1'b1;
        st_next.rdata[k] = '0;
      end
      for (int b = 0; b < BLOCKS; b++) begin
        if (serve[b][k]) begin
          st_next.ack[k] = 1'b1;
          st_next.rdata[k] = mem[b][bus.addr[k]];
        end else if (nulled[b][k]) begin
          st_next.ack[k] = 1'b1;
          st_next.rdata[k] = '0;
        end
      end
      // only plain cpu and accel data accesses reach peripherals
      if (pq[k] && k != K_DWR && k != K_DRD && k != K_AWR && k != K_ARD)
      begin
        st_next.ack[k] = 1'b1;
        st_next.rdata[k] = '0;
      end
    end
    st_next.trap = |zfet;
    st_next.illegal = |ill;

    unique case (st_reg.peri)
      PERI_IDLE: begin
        st_next.peri_cnt = 2'h0;
        // accel chosen first whenever the bus is free
        // write ahead of read within each master
        if (pq[K_AWR]) begin
          st_next.peri = PERI_ACC;
          st_next.peri_kind = 4'(K_AWR);
        end else if (pq[K_ARD]) begin
          st_next.peri = PERI_ACC;
          st_next.peri_kind = 4'(K_ARD);
        end else if (pq[K_DWR]) begin
          st_next.peri = PERI_CPU;
          st_next.peri_kind = 4'(K_DWR);
        end else if (pq[K_DRD]) begin
          st_next.peri = PERI_CPU;
          st_next.peri_kind = 4'(K_DRD);
        end
      end
      PERI_CPU, PERI_ACC: begin
        // runs to completion, the other master waits
        // no lock across a cpu read-modify-write: an accel write
        // landing between its halves is lost
        st_next.peri_cnt = st_reg.peri_cnt + 2'h1;
        if (st_reg.peri_cnt == PERI_LAST) begin
          st_next.peri = PERI_IDLE;
          st_next.ack[st_reg.peri_kind] = 1'b1;
          st_next.rdata[st_reg.peri_kind] =
            preg[bus.addr[st_reg.peri_kind]];
          peri_we = WR_KINDS[st_reg.peri_kind];
        end
      end
    endcase

    // level already high at setup never looks like an edge
    st_next.trig_prev = bus.trig_src;
    st_next.trig = st_reg.trig_prev & ~bus.trig_src;
    // vector is an offset into program ram
    st_next.task_pc = PROG_BASE + bus.task_vector;
    // completion and flag interrupts to the host
    st_next.irq = {bus.accel_unf, bus.accel_ovf, bus.task_done};
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RESET;
      st_reg.cfg_pend <= CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // no reset on storage: contents are undefined until written
  always_ff @(posedge pclk) begin
    for (int b = 0; b < BLOCKS; b++) begin
      for (int k = 0; k < KINDS; k++) begin
        if (serve[b][k] && WR_KINDS[k]) mem[b][bus.addr[k]] <= bus.wdata[k];
      end
    end
    if (peri_we) preg[bus.addr[st_reg.peri_kind]] <=
      bus.wdata[st_reg.peri_kind];
  end

  ////////////////////////////////////////////////////////////////////////
  // every output is a field of the state register
  assign bus.ack = st_reg.ack;
  assign bus.rdata = st_reg.rdata;
  assign bus.cpu_trap = st_reg.trap;
  assign bus.accel_illegal = st_reg.illegal;
  assign bus.task_trigger = st_reg.trig;
  assign bus.task_pc = st_reg.task_pc;
  assign bus.host_irq = st_reg.irq;
  assign map_active = st_reg.cfg;
endmodule

// *** src/asma_host.sv ***
`timescale 1ns/1ps
module asma_host (
  input wire logic pclk,
  input wire logic presetn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  asma_if.host bus
);
  import asma_pkg::*;

  typedef struct packed {
    logic [KINDS-1:0] req;
    logic [KINDS-1:0][TW-1:0] tgt;
    logic [KINDS-1:0][AW-1:0] addr;
    logic [KINDS-1:0][DW-1:0] wdata;
    logic [DW-1:0] data;
    logic [CFG_W-1:0] cfg;
    logic cfg_wr;
    logic [1:0] settle;
    logic running;
    logic [TASKS-1:0] trig;
    logic [DW-1:0] vec;
    logic [TASKS-1:0] done;
    logic ovf;
    logic unf;
    logic [DW-1:0] rd_last;
    logic trap;
    logic illegal;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } asma_host_state_type;

  asma_host_state_type st_reg;
  asma_host_state_type st_next;
  logic we;
  logic [3:0] kind;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    kind = pwdata[3:0];
    we = psel && penable && pwrite && st_reg.pready;
    st_next.cfg_wr = 1'b0;
    st_next.done = '0;
    st_next.ovf = 1'b0;
    st_next.unf = 1'b0;
    if (st_reg.settle != 2'h0) st_next.settle = st_reg.settle - 2'h1;
    for (int k = 0; k < KINDS; k++) begin
      if (bus.ack[k]) begin
        st_next.req[k] = 1'b0;
        if (!WR_KINDS[k]) st_next.rd_last = bus.rdata[k];
      end
    end
    if (we) begin
      case (paddr)
        A_CFG: begin
          // ownership held while the accelerator runs
          // no second change before the first settles
          if (!st_reg.running && st_reg.settle == 2'h0) begin
            st_next.cfg = pwdata[CFG_W-1:0];
            st_next.cfg_wr = 1'b1;
            st_next.settle = CFG_SETTLE;
          end
        end
        A_CMD: begin
          // ownership not relied on until settled
          if (kind < 4'(KINDS) && !st_reg.req[kind] &&
              st_reg.settle == 2'h0) begin
            st_next.req[kind] = 1'b1;
            st_next.tgt[kind] = pwdata[6:4];
            st_next.addr[kind] = pwdata[13:8];
            st_next.wdata[kind] = st_reg.data;
          end
        end
        A_DATA: st_next.data = pwdata[DW-1:0];
        A_STAT: begin
          if (pwdata[16]) st_next.trap = 1'b0;
          if (pwdata[17]) st_next.illegal = 1'b0;
        end
        A_CTRL: begin
          st_next.running = pwdata[0];
          st_next.trig = pwdata[15:8];
          st_next.ovf = pwdata[16];
          st_next.unf = pwdata[17];
        end
        A_TASK: begin
          st_next.vec = pwdata[15:0];
          st_next.done = pwdata[23:16];
        end
        default: ;
      endcase
    end
    // a trap in the clearing cycle survives the clear
    if (bus.cpu_trap) st_next.trap = 1'b1;
    if (bus.accel_illegal) st_next.illegal = 1'b1;

    // zero wait: answer in the first access cycle
    st_next.pready = psel && !penable;
    st_next.pslverr = 1'b0;
    st_next.prdata = '0;
    if (psel && !penable) begin
      case (paddr)
        A_CFG: st_next.prdata = 32'(st_reg.cfg);
        A_CMD: ;
        A_DATA: st_next.prdata = 32'(st_reg.data);
        A_STAT: st_next.prdata = {13'h0000, st_reg.settle != 2'h0,
          st_reg.illegal, st_reg.trap, 6'h00, st_reg.req};
        A_RDAT: st_next.prdata = 32'(st_reg.rd_last);
        A_CTRL: st_next.prdata = {16'h0000, st_reg.trig, 7'h00,
          st_reg.running};
        A_TASK: st_next.prdata = 32'(st_reg.vec);
        default: st_next.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign bus.req = st_reg.req;
  assign bus.tgt = st_reg.tgt;
  assign bus.addr = st_reg.addr;
  assign bus.wdata = st_reg.wdata;
  assign bus.cfg_wr = st_reg.cfg_wr;
  assign bus.cfg_data = st_reg.cfg;
  assign bus.accel_running = st_reg.running;
  assign bus.trig_src = st_reg.trig;
  assign bus.task_vector = st_reg.vec;
  assign bus.task_done = st_reg.done;
  assign bus.accel_ovf = st_reg.ovf;
  assign bus.accel_unf = st_reg.unf;
endmodule

// *** bench/asma_checker.sv ***
`timescale 1ns/1ps
module asma_checker (
  input logic pclk,
  input logic presetn,
  input logic [asma_pkg::KINDS-1:0][asma_pkg::TW-1:0] tgt,
  input logic [asma_pkg::KINDS-1:0] ack,
  input logic [asma_pkg::KINDS-1:0][asma_pkg::DW-1:0] rdata,
  input logic cfg_wr,
  input logic [asma_pkg::CFG_W-1:0] cfg_data,
  input logic accel_running,
  input logic cpu_trap,
  input logic accel_illegal,
  input logic [asma_pkg::TASKS-1:0] trig_src,
  input logic [asma_pkg::TASKS-1:0] task_trigger,
  input logic [asma_pkg::DW-1:0] task_vector,
  input logic [asma_pkg::DW-1:0] task_pc,
  input logic [asma_pkg::TASKS-1:0] task_done,
  input logic accel_ovf,
  input logic accel_unf,
  input logic [asma_pkg::TASKS+1:0] host_irq,
  input logic [asma_pkg::CFG_W-1:0] map_active
);
  import asma_pkg::*;
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  logic cfg_seen_reg;
  logic acc_rd_refused;
  logic cpu_rd_refused;
  logic peri_ack;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_seen_reg <= 1'b0;
    end else if (cfg_wr) begin
      cfg_seen_reg <= 1'b1;
    end
  end
  // refusal decoded from the map in force when the answer lands
  always_comb begin
    acc_rd_refused = 1'b0;
    cpu_rd_refused = 1'b0;
    peri_ack = 1'b0;
    for (int b = 0; b < 3; b++) begin
      if (tgt[K_ARD] == TW'(b + 1)) begin
        acc_rd_refused = !map_active[CFG_RAM_LSB + b];
      end
      if (tgt[K_DRD] == TW'(b + 1)) begin
        cpu_rd_refused = map_active[CFG_RAM_LSB + b] &&
          !map_active[CFG_SHARE_LSB + b];
      end
    end
    for (int k = 0; k < KINDS; k++) begin
      peri_ack = peri_ack | (ack[k] && (tgt[k] == T_PERI));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  map_settle_a: assert property (
    cfg_wr |-> ##2 (map_active == $past(cfg_data, 2)))
    else $error("map change not in force two cycles after write");
  reset_map_a: assert property (
    !cfg_seen_reg |-> (map_active == CFG_RESET))
    else $error("map not cpu owned after reset");
  fetch_trap_a: assert property (
    ack[K_FET] && tgt[K_FET] == 3'h0 && map_active[CFG_PROG]
    |-> (rdata[K_FET] == 16'h0000) ##[0:1] cpu_trap)
    else $error("cpu fetch of accel program ram not zero with trap");
  acc_illegal_a: assert property (
    ack[K_AFET] && tgt[K_AFET] == 3'h0 && !map_active[CFG_PROG]
    |-> ##[0:1] accel_illegal)
    else $error("accel fetch of cpu program ram not flagged");
  debug_zero_a: assert property (
    ack[K_GRD] && tgt[K_GRD] == 3'h0 && map_active[CFG_PROG] &&
    accel_running |-> rdata[K_GRD] == 16'h0000)
    else $error("debug read while running not zero");
  acc_rd_zero_a: assert property (
    ack[K_ARD] && acc_rd_refused |-> rdata[K_ARD] == 16'h0000)
    else $error("accel read of cpu block not zero");
  cpu_rd_zero_a: assert property (
    ack[K_DRD] && cpu_rd_refused |-> rdata[K_DRD] == 16'h0000)
    else $error("cpu read of unshared accel block not zero");
  peri_serial_a: assert property (
    peri_ack |=> !peri_ack)
    else $error("peripheral accesses overlap");
  trig_edge_a: assert property (
    task_trigger == ($past(trig_src, 2) & ~$past(trig_src)))
    else $error("task trigger not on falling source edge");
  vector_pc_a: assert property (
    task_pc == PROG_BASE + $past(task_vector))
    else $error("task start not offset from program base");
  irq_map_a: assert property (
    host_irq == {$past(accel_unf), $past(accel_ovf), $past(task_done)})
    else $error("host interrupt lines wrong");
  cover property (cfg_wr ##2 map_active[CFG_PROG]);
  cover property (peri_ack);
  cover property (|task_trigger);
endmodule

// *** bench/tb_accel_shared_memory_arbiter.sv ***
`timescale 1ns/1ps
module tb_accel_shared_memory_arbiter;
  import asma_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [CFG_W-1:0] map_active;
  logic [TASKS+1:0] irq_seen;
  logic [TASKS-1:0] trig_seen;
  int mismatches, check_count;
  asma_if bus();
  asma_device u_asma_device (.pclk(pclk), .presetn(presetn), .bus(bus),
    .map_active(map_active));
  asma_host u_asma_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  asma_checker u_asma_checker (.pclk(pclk), .presetn(presetn),
    .tgt(bus.tgt), .ack(bus.ack), .rdata(bus.rdata), .cfg_wr(bus.cfg_wr),
    .cfg_data(bus.cfg_data), .accel_running(bus.accel_running),
    .cpu_trap(bus.cpu_trap), .accel_illegal(bus.accel_illegal),
    .trig_src(bus.trig_src), .task_trigger(bus.task_trigger),
    .task_vector(bus.task_vector), .task_pc(bus.task_pc),
    .task_done(bus.task_done), .accel_ovf(bus.accel_ovf),
    .accel_unf(bus.accel_unf), .host_irq(bus.host_irq),
    .map_active(map_active));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // pulses are short, so they are collected for later comparison
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_seen <= '0;
      irq_seen <= '0;
    end else begin
      trig_seen <= trig_seen | bus.task_trigger;
      irq_seen <= irq_seen | bus.host_irq;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps strobes from being re-driven
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, A_STAT, 32'h0000_0000);
    check(rd & m, e);
    apb(1'b1, A_STAT, m);
  endtask
  task automatic cfgw(input logic [CFG_W-1:0] v);
    apb(1'b1, A_CFG, {25'h000_0000, v});
    repeat (2) @(posedge pclk);
    check({25'h000_0000, map_active}, {25'h000_0000, v});
  endtask
  task automatic go(input int k, input logic [2:0] t, input logic [5:0] a,
      input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, A_DATA, {16'h0000, d});
    apb(1'b1, A_CMD, {18'h0_0000, a, 1'b0, t, 4'(k)});
    do begin
      apb(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end while (rd[9:0] !== 10'h000 && n < 40);
    check({22'h00_0000, rd[9:0]}, 32'h0000_0000);
  endtask
  task automatic rdk(input int k, input logic [2:0] t, input logic [5:0] a,
      input logic [15:0] e);
    go(k, t, a, 16'h0000);
    check({16'h0000, bus.rdata[k]}, {16'h0000, e});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(A_CFG, 32'h0000_0000);
    rdchk(8'h1c, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    for (int b = 0; b < 3; b++) begin
      go(K_DWR, 3'(b + 1), 6'h05, 16'h1000 + 16'(b));
    end
    cfgw(7'h04);
    rdk(K_DRD, 3'h1, 6'h05, 16'h1000);
    rdk(K_DRD, 3'h2, 6'h05, 16'h0000);
    rdk(K_DRD, 3'h3, 6'h05, 16'h1002);
    rdk(K_ARD, 3'h2, 6'h05, 16'h1001);
    go(K_AWR, 3'h2, 6'h05, 16'h2222);
    go(K_DWR, 3'h2, 6'h05, 16'h3333);
    rdk(K_GRD, 3'h2, 6'h05, 16'h2222);
    rdk(K_PRD, 3'h2, 6'h05, 16'h0000);
    go(K_GWR, 3'h2, 6'h05, 16'h4444);
    rdk(K_ARD, 3'h2, 6'h05, 16'h4444);
    rdk(K_FET, 3'h2, 6'h05, 16'h0000);
    stat(32'h0001_0000, 32'h0001_0000);
    cfgw(7'h24);
    rdk(K_DRD, 3'h2, 6'h05, 16'h4444);
    go(K_DWR, 3'h2, 6'h05, 16'h5555);
    go(K_PWR, 3'h2, 6'h05, 16'h6666);
    rdk(K_ARD, 3'h2, 6'h05, 16'h5555);
    rdk(K_PRD, 3'h2, 6'h05, 16'h0000);
    cfgw(7'h00);
    rdk(K_ARD, 3'h2, 6'h05, 16'h0000);
    go(K_AWR, 3'h2, 6'h05, 16'h7777);
    rdk(K_DRD, 3'h2, 6'h05, 16'h5555);
    ////////////////////////////////////////////////////////////////////////
    go(K_PWR, 3'h0, 6'h02, 16'ha5a5);
    rdk(K_FET, 3'h0, 6'h02, 16'ha5a5);
    go(K_AFET, 3'h0, 6'h02, 16'h0000);
    stat(32'h0003_0000, 32'h0002_0000);
    cfgw(7'h01);
    rdk(K_FET, 3'h0, 6'h02, 16'h0000);
    stat(32'h0003_0000, 32'h0001_0000);
    rdk(K_DRD, 3'h0, 6'h02, 16'h0000);
    go(K_DWR, 3'h0, 6'h02, 16'h1111);
    rdk(K_AFET, 3'h0, 6'h02, 16'ha5a5);
    go(K_GWR, 3'h0, 6'h03, 16'h7777);
    rdk(K_GRD, 3'h0, 6'h03, 16'h7777);
    rdchk(A_RDAT, 32'h0000_7777);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    rdk(K_GRD, 3'h0, 6'h03, 16'h0000);
    go(K_GWR, 3'h0, 6'h03, 16'h8888);
    apb(1'b1, A_CFG, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check({25'h000_0000, map_active}, 32'h0000_0001);
    apb(1'b1, A_CTRL, 32'h0000_0000);
    rdk(K_GRD, 3'h0, 6'h03, 16'h7777);
    cfgw(7'h00);
    ////////////////////////////////////////////////////////////////////////
    // each master keeps to its own peripheral word
    go(K_DWR, T_PERI, 6'h01, 16'h00c3);
    rdk(K_DRD, T_PERI, 6'h01, 16'h00c3);
    go(K_AWR, T_PERI, 6'h02, 16'h003c);
    rdk(K_ARD, T_PERI, 6'h02, 16'h003c);
    // vector is set up before any trigger source moves
    apb(1'b1, A_TASK, 32'h0000_0123);
    apb(1'b1, A_CTRL, 32'h0000_0500);
    repeat (3) @(posedge pclk);
    check({24'h00_0000, trig_seen}, 32'h0000_0000);
    apb(1'b1, A_CTRL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check({24'h00_0000, trig_seen}, 32'h0000_0005);
    apb(1'b1, A_TASK, 32'h0081_0123);
    apb(1'b1, A_CTRL, 32'h0003_0000);
    repeat (3) @(posedge pclk);
    check({16'h0000, bus.task_pc}, {16'h0000, PROG_BASE + 16'h0123});
    check({22'h00_0000, irq_seen}, 32'h0000_0381);
    report_and_stop();
  end
endmodule
